// >>> core/ricg_pkg.sv
// Constants and types shared by the remote command gate.
// Assumes one 10 MHz clock; registers sit on a plain strobe port.
package ricg_pkg;

    // Clock figures
    localparam int CLK_PERIOD_NS = 100;

    // Function slots of the input map table
    localparam int F_START = 0;
    localparam int F_PROG0 = 1;
    localparam int F_STOP = 7;
    localparam int F_PAUSE = 8;
    localparam int F_CONT = 9;
    localparam int F_RESET = 10;
    localparam int F_FORCE = 11;
    localparam int F_RSEL = 12;
    localparam int F_RNUM0 = 13;
    localparam int NFUNC = 18;
    localparam int NPROG = 6;
    localparam int NRNUM = 5;

    // Map entry layout: valid flag above a 5-bit input index
    localparam int MAP_W = 6;
    localparam int MAP_VALID = 5;
    localparam int MAP_IDX_W = 5;

    // Command vector positions
    localparam int C_START = 0;
    localparam int C_STOP = 1;
    localparam int C_PAUSE = 2;
    localparam int C_CONT = 3;
    localparam int C_RESET = 4;
    localparam int C_RSEL = 5;
    localparam int NCMD = 6;

    // Register offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h10;
    localparam logic [7:0] ADDR_MAP_BASE = 8'h40;

    // Control register fields and reset value
    localparam int CTRL_W = 3;
    localparam int CTRL_REMOTE = 0;
    localparam int CTRL_REJ_OUT = 1;
    localparam int CTRL_FORCE_STOP = 2;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h4;

    // Status register fields
    localparam int STAT_AUTO = 0;
    localparam int STAT_REJ = 1;
    localparam int STAT_FORCED = 2;
    localparam int STAT_REMOTE = 3;
    localparam int STAT_PROG = 4;
    localparam int STAT_RNUM = 10;
    localparam int STAT_SHOWN = 15;

    // Interrupt bits
    localparam int IRQ_W = 3;
    localparam int IRQ_ACCEPT = 0;
    localparam int IRQ_REJECT = 1;
    localparam int IRQ_FORCED = 2;
    localparam logic [IRQ_W-1:0] IRQ_EN_RESET = 3'h0;

    // Map reset values: start, three program lines and four commands
    localparam logic [MAP_W-1:0] MAP_RESET [NFUNC] = '{
        6'h20, 6'h21, 6'h22, 6'h23, 6'h00, 6'h00, 6'h00,
        6'h24, 6'h25, 6'h26, 6'h27, 6'h00, 6'h00,
        6'h00, 6'h00, 6'h00, 6'h00, 6'h00
    };

    typedef enum logic [1:0] {
        PW_NORMAL = 2'b01,
        PW_FORCED = 2'b10
    } ricg_pw_t;

endpackage

// >>> core/ricg_sync_edge.sv
// Two-stage synchroniser with rising-edge detection for a bit vector.
// Assumes the inputs may change at any time relative to clk.
`timescale 1ns/10ps
`default_nettype none
module ricg_sync_edge #(
    parameter int W = 32
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [W-1:0] din,
    output logic [W-1:0] level,
    output logic [W-1:0] rise
);
    logic [W-1:0] meta;
    logic [W-1:0] sync;
    logic [W-1:0] prev;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta <= '0;
            sync <= '0;
            prev <= '0;
        end else if (ce) begin
            meta <= din;
            sync <= meta;
            prev <= sync;
        end
    end

    assign level = sync;
    assign rise = sync & ~prev;
endmodule
`default_nettype wire

// >>> core/ricg_gate.sv
// Remote command gate: maps remote input bits to functions, tests each
// rising edge against its acceptance condition, issues command pulses.
// Assumes controller status inputs are synchronous to clk.
//
// Functional notes
// - Each command fires on its input's rising edge only if its condition holds.
// - Commands honoured only with functions mapped and remote control source selected.
// - Automatic-mode output is high while remote input is being accepted.
// - While error is set every command but reset is refused; host resets first.
// - A refused command edge is not executed and raises command reject instead.
// - Command reject drives no output until explicitly assigned to one.
// - Start needs ready, no error, no e-stop, guard closed, e-stop clear, no pause/stop.
// - Six program lines form a binary number 0..63; bits 1,2,3 mapped by default.
// - Stop, default bit 4, halts everything; its only precondition is no error.
// - Pause, default bit 5, accepted only while running is on.
// - Continue, default bit 6, needs paused on and pause, stop inputs off.
// - Reset, default bit 7, clears e-stop and error, needs ready.
// - Forced low power accepted any time; holds low power, stops or pauses tasks.
// - While forced low power is active, high power requests are refused.
// - Robot status select picks which robot's state drives the four status outputs.
// - Five robot-number lines form a binary number 0..31; all unmapped by default.
// - In teach mode all commands are refused while status outputs keep running.
`timescale 1ns/10ps
`default_nettype none
module ricg_gate
    import ricg_pkg::*;
#(
    parameter int IN_W = 32,
    parameter int NROB = 32
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [IN_W-1:0] remote_in,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic ready,
    input wire logic error,
    input wire logic emergency_stop_active,
    input wire logic emergency_stop_clear,
    input wire logic guard_open_flag,
    input wire logic running,
    input wire logic paused,
    input wire logic manual_teaching_flag,
    input wire logic [NROB-1:0] drive_power_on_all,
    input wire logic [NROB-1:0] arm_at_park_all,
    input wire logic [NROB-1:0] full_power_all,
    input wire logic [NROB-1:0] calibration_needed_all,
    input wire logic high_power_request,
    output logic automatic_mode_flag,
    output logic start_pulse,
    output logic [NPROG-1:0] program_select,
    output logic stop_pulse,
    output logic pause_pulse,
    output logic continue_pulse,
    output logic reset_pulse,
    output logic low_power_hold,
    output logic high_power_grant,
    output logic high_power_refuse,
    output logic [NRNUM-1:0] robot_number_line,
    output logic [NRNUM-1:0] robot_status_select,
    output logic drive_power_on,
    output logic arm_at_park,
    output logic full_power_flag,
    output logic calibration_needed,
    output logic command_reject_flag,
    output logic irq
);

    // Picks one synchronised input bit through a map entry
    function automatic logic pick(input logic [IN_W-1:0] v, input logic [MAP_W-1:0] m);
        logic hit;
        hit = 1'b0;
        if (m[MAP_VALID] && (32'(m[MAP_IDX_W-1:0]) < IN_W)) begin
            hit = v[m[MAP_IDX_W-1:0]];
        end
        return hit;
    endfunction

    logic [IN_W-1:0] s_lvl;
    logic [IN_W-1:0] s_rise;
    logic [MAP_W-1:0] map [NFUNC];
    logic [NFUNC-1:0] f_lvl;
    logic [NFUNC-1:0] f_rise;
    logic [NFUNC-1:0] f_valid;
    logic [CTRL_W-1:0] ctrl;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_en;
    logic rej_flag;
    logic [NRNUM-1:0] shown_robot;
    ricg_pw_t pw_state;
    ricg_pw_t next_pw_state;

    ricg_sync_edge #(
        .W(IN_W)
    ) u_sync (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .din(remote_in),
        .level(s_lvl),
        .rise(s_rise)
    );

    // Map each function to its input bit
    genvar gi;
    generate
        for (gi = 0; gi < NFUNC; gi++) begin : g_map
            assign f_lvl[gi] = pick(s_lvl, map[gi]);
            assign f_rise[gi] = pick(s_rise, map[gi]);
            assign f_valid[gi] = map[gi][MAP_VALID];
        end
    endgenerate

    // Remote gating
    wire remote_on = ctrl[CTRL_REMOTE] & (|f_valid);
    wire auto_ok = remote_on & ~manual_teaching_flag;
    wire pause_in = f_lvl[F_PAUSE];
    wire stop_in = f_lvl[F_STOP];
    wire [NPROG-1:0] prog_lines = f_lvl[F_PROG0 +: NPROG];
    wire [NRNUM-1:0] rnum_lines = f_lvl[F_RNUM0 +: NRNUM];

    // Acceptance conditions
    wire cond_start = ready & ~emergency_stop_active & ~guard_open_flag
        & emergency_stop_clear & ~pause_in & ~stop_in;
    wire cond_stop = 1'b1;
    wire cond_pause = running;
    wire cond_cont = paused & ~pause_in & ~stop_in;
    wire cond_reset = ready;
    wire cond_rsel = 1'b1;

    wire [NCMD-1:0] cmd_edge = {f_rise[F_RSEL], f_rise[F_RESET], f_rise[F_CONT],
        f_rise[F_PAUSE], f_rise[F_STOP], f_rise[F_START]};
    wire [NCMD-1:0] cmd_cond = {cond_rsel, cond_reset, cond_cont,
        cond_pause, cond_stop, cond_start};
    wire [NCMD-1:0] err_ok = {{(NCMD-C_RESET){1'b1}} & {~error, 1'b1},
        {C_RESET{~error}}};
    wire [NCMD-1:0] cmd_ok = cmd_cond & err_ok & {NCMD{auto_ok}};
    wire [NCMD-1:0] cmd_acc = cmd_edge & cmd_ok & {NCMD{remote_on}};
    wire [NCMD-1:0] cmd_rej = cmd_edge & ~cmd_ok & {NCMD{remote_on}};

    // Forced low power, level sensitive and independent of automatic mode
    wire force_lvl = remote_on & f_lvl[F_FORCE];
    wire force_entry = (pw_state == PW_NORMAL) & force_lvl;

    always_comb begin
        case (pw_state)
            PW_NORMAL: next_pw_state = force_lvl ? PW_FORCED : PW_NORMAL;
            PW_FORCED: next_pw_state = force_lvl ? PW_FORCED : PW_NORMAL;
            default: next_pw_state = PW_NORMAL;
        endcase
    end

    wire force_stop = force_entry & ctrl[CTRL_FORCE_STOP];
    wire force_pause = force_entry & ~ctrl[CTRL_FORCE_STOP];
    wire hp_forced = force_lvl | (pw_state == PW_FORCED);

    // Register decode
    wire in_map = (addr >= ADDR_MAP_BASE) && (addr < ADDR_MAP_BASE + 8'(NFUNC * 4))
        && (addr[1:0] == 2'b00);
    wire [7:0] map_sel = 8'((addr - ADDR_MAP_BASE) >> 2);
    wire wr_ctrl = wr & (addr == ADDR_CTRL);
    wire wr_en = wr & (addr == ADDR_IRQ_EN);
    wire wr_clr = wr & (addr == ADDR_IRQ_CLR);
    wire wr_map = wr & in_map;
    wire [IRQ_W-1:0] irq_set = {force_entry, |cmd_rej, |cmd_acc};
    wire [IRQ_W-1:0] irq_clr = wr_clr ? wdata[IRQ_W-1:0] : '0;

    logic [31:0] stat_word;
    logic [31:0] rd_word;
    always_comb begin
        stat_word = '0;
        stat_word[STAT_AUTO] = automatic_mode_flag;
        stat_word[STAT_REJ] = rej_flag;
        stat_word[STAT_FORCED] = low_power_hold;
        stat_word[STAT_REMOTE] = remote_on;
        stat_word[STAT_PROG +: NPROG] = program_select;
        stat_word[STAT_RNUM +: NRNUM] = robot_number_line;
        stat_word[STAT_SHOWN +: NRNUM] = shown_robot;
        rd_word = '0;
        if (addr == ADDR_CTRL) begin
            rd_word[CTRL_W-1:0] = ctrl;
        end else if (addr == ADDR_STAT) begin
            rd_word = stat_word;
        end else if (addr == ADDR_IRQ_STAT) begin
            rd_word[IRQ_W-1:0] = irq_stat;
        end else if (addr == ADDR_IRQ_EN) begin
            rd_word[IRQ_W-1:0] = irq_en;
        end else if (in_map) begin
            rd_word[MAP_W-1:0] = map[map_sel[4:0]];
        end
    end

    // Register file
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl <= CTRL_RESET;
            irq_en <= IRQ_EN_RESET;
            irq_stat <= '0;
            rdata <= '0;
        end else if (ce) begin
            if (wr_ctrl) begin
                ctrl <= wdata[CTRL_W-1:0];
            end
            if (wr_en) begin
                irq_en <= wdata[IRQ_W-1:0];
            end
            irq_stat <= (irq_stat & ~irq_clr) | irq_set;
            rdata <= rd ? rd_word : '0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < NFUNC; i++) begin
                map[i] <= MAP_RESET[i];
            end
        end else if (ce && wr_map) begin
            map[map_sel[4:0]] <= wdata[MAP_W-1:0];
        end
    end

    // Command outputs
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            start_pulse <= 1'b0;
            stop_pulse <= 1'b0;
            pause_pulse <= 1'b0;
            continue_pulse <= 1'b0;
            reset_pulse <= 1'b0;
            program_select <= '0;
        end else if (ce) begin
            start_pulse <= cmd_acc[C_START];
            stop_pulse <= cmd_acc[C_STOP] | force_stop;
            pause_pulse <= cmd_acc[C_PAUSE] | force_pause;
            continue_pulse <= cmd_acc[C_CONT];
            reset_pulse <= cmd_acc[C_RESET];
            if (cmd_acc[C_START]) begin
                program_select <= prog_lines;
            end
        end
    end

    // Power mode, reject flag and mode status
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pw_state <= PW_NORMAL;
            low_power_hold <= 1'b0;
            high_power_grant <= 1'b0;
            high_power_refuse <= 1'b0;
            rej_flag <= 1'b0;
            command_reject_flag <= 1'b0;
            automatic_mode_flag <= 1'b0;
        end else if (ce) begin
            pw_state <= next_pw_state;
            low_power_hold <= (next_pw_state == PW_FORCED);
            high_power_grant <= high_power_request & ~hp_forced;
            high_power_refuse <= high_power_request & hp_forced;
            if (|cmd_rej) begin
                rej_flag <= 1'b1;
            end else if (|cmd_acc) begin
                rej_flag <= 1'b0;
            end
            command_reject_flag <= ctrl[CTRL_REJ_OUT] & (rej_flag | (|cmd_rej));
            automatic_mode_flag <= auto_ok;
        end
    end

    // Robot selection and per-robot status
    wire [NRNUM-1:0] shown_idx = shown_robot;
    wire shown_ok = 32'(shown_idx) < NROB;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            shown_robot <= '0;
            robot_number_line <= '0;
            robot_status_select <= '0;
            drive_power_on <= 1'b0;
            arm_at_park <= 1'b0;
            full_power_flag <= 1'b0;
            calibration_needed <= 1'b0;
        end else if (ce) begin
            robot_number_line <= rnum_lines;
            if (cmd_acc[C_RSEL]) begin
                shown_robot <= rnum_lines;
            end
            robot_status_select <= shown_robot;
            drive_power_on <= shown_ok & drive_power_on_all[shown_idx];
            arm_at_park <= shown_ok & arm_at_park_all[shown_idx];
            full_power_flag <= shown_ok & full_power_all[shown_idx];
            calibration_needed <= shown_ok & calibration_needed_all[shown_idx];
        end
    end

    assign irq = |(irq_stat & irq_en);

endmodule
`default_nettype wire

// >>> tb/ricg_gate_sva.sv
// Concurrent checks on the remote command gate ports.
// Assumes the default input map; pauses issued on forced-power entry are exempt.
`timescale 1ns/10ps
`default_nettype none
module ricg_gate_sva
    import ricg_pkg::*;
#(
    parameter int IN_W = 32
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [IN_W-1:0] remote_in,
    input wire logic ready,
    input wire logic error,
    input wire logic emergency_stop_active,
    input wire logic emergency_stop_clear,
    input wire logic guard_open_flag,
    input wire logic running,
    input wire logic paused,
    input wire logic manual_teaching_flag,
    input wire logic high_power_request,
    input wire logic automatic_mode_flag,
    input wire logic start_pulse,
    input wire logic [NPROG-1:0] program_select,
    input wire logic pause_pulse,
    input wire logic continue_pulse,
    input wire logic reset_pulse,
    input wire logic low_power_hold,
    input wire logic high_power_refuse,
    input wire logic command_reject_flag
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_start_rise; $rose(remote_in[0]); endsequence
    sequence s_start_ok;
        automatic_mode_flag && ready && !error && !emergency_stop_active && emergency_stop_clear
            && !guard_open_flag && !manual_teaching_flag && !remote_in[4] && !remote_in[5];
    endsequence
    // Edge needs two stages to reach the detector, pulse lands one edge later
    property p_start; s_start_rise ##2 s_start_ok |-> ##1 start_pulse; endproperty
    a_start: assert property (p_start) else $error("start edge not executed");
    property p_prog; start_pulse |-> program_select == {3'h0, $past(remote_in[3:1], 3)}; endproperty
    a_prog: assert property (p_prog) else $error("program number wrong");
    property p_pause; pause_pulse && !$rose(low_power_hold) |-> $past(running); endproperty
    a_pause: assert property (p_pause) else $error("pause without running");
    property p_cont; continue_pulse |-> $past(paused); endproperty
    a_cont: assert property (p_cont) else $error("continue without paused");
    property p_reset; reset_pulse |-> $past(ready); endproperty
    a_reset: assert property (p_reset) else $error("reset without ready");
    property p_err;
        start_pulse || continue_pulse || pause_pulse && !$rose(low_power_hold) |-> !$past(error);
    endproperty
    a_err: assert property (p_err) else $error("command run while error set");
    property p_teach; manual_teaching_flag [*2] |-> !automatic_mode_flag; endproperty
    a_teach: assert property (p_teach) else $error("auto mode during teach");
    property p_noauto;
        !automatic_mode_flag [*4]
            |-> !(start_pulse || pause_pulse && !$rose(low_power_hold) || continue_pulse || reset_pulse);
    endproperty
    a_noauto: assert property (p_noauto) else $error("command without remote control");
    property p_hp; low_power_hold && high_power_request |-> ##1 high_power_refuse; endproperty
    a_hp: assert property (p_hp) else $error("high power not refused");
    // Reject output drops one cycle after the accepting pulse
    property p_rejclr; start_pulse |=> !command_reject_flag; endproperty
    a_rejclr: assert property (p_rejclr) else $error("reject kept after accepted start");
endmodule
`default_nettype wire

// >>> tb/ricg_host_model.sv
// Remote host model: pulses one command bit over a background of levels.
// Assumes the gate synchronises remote_in itself.
`timescale 1ns/10ps
`default_nettype none
module ricg_host_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic req,
    input wire logic obey,
    input wire logic auto_on,
    input wire logic ready,
    input wire logic [4:0] idx,
    input wire logic [31:0] levels,
    output logic [31:0] remote_in,
    output logic busy
);
    logic [2:0] cnt;
    logic [4:0] sel;
    wire logic hold_off = obey && !(auto_on && ready) && cnt == 3'h0;
    // High for three cycles, low for four: one clean edge per request
    assign remote_in = levels | ((busy && cnt != 3'h0 && cnt < 3'h4) ? 32'h0000_0001 << sel : 32'h0000_0000);
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt <= 3'h0;
            busy <= 1'b0;
            sel <= 5'h00;
        end else if (req && !busy) begin
            busy <= 1'b1;
            sel <= idx;
        end else if (busy && !hold_off) begin
            cnt <= cnt + 3'h1;
            busy <= cnt != 3'h7;
        end
    end
endmodule
`default_nettype wire

// >>> tb/tb_ricg_gate.sv
// Bench for the remote command gate: bus tasks, host model, command table.
// Assumes the default input map and a 10 MHz clock.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; $display("Error %0t: got %h want %h", $time, a, b); end end
module tb_ricg_gate
    import ricg_pkg::*;
;
    logic clk, nrst, ce, wr, rd, req, obey, busy, high_power_request, sp, high_power_grant;
    logic ready, error, emergency_stop_active, emergency_stop_clear, guard_open_flag, running, paused;
    logic manual_teaching_flag, automatic_mode_flag, start_pulse, stop_pulse, pause_pulse, continue_pulse;
    logic reset_pulse, low_power_hold, high_power_refuse, drive_power_on, arm_at_park, command_reject_flag, irq;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, remote_in, levels, rv;
    logic [4:0] hidx;
    logic [NPROG-1:0] program_select;
    logic [NRNUM-1:0] robot_number_line, robot_status_select;
    int bad_count, num_checks, n;
    // Status {ready,error,estop,estop clear,guard,running,paused,teach}, bit, pulses, reject
    localparam logic [18:0] ROWS [13] = '{
        {8'h98, 5'h00, 5'h00, 1'b1},
        {8'hB0, 5'h00, 5'h00, 1'b1},
        {8'h10, 5'h00, 5'h00, 1'b1},
        {8'hD0, 5'h00, 5'h00, 1'b1},
        {8'hD0, 5'h04, 5'h00, 1'b1},
        {8'h50, 5'h07, 5'h00, 1'b1},
        {8'hD0, 5'h07, 5'h10, 1'b0},
        {8'h90, 5'h05, 5'h00, 1'b1},
        {8'h94, 5'h05, 5'h04, 1'b0},
        {8'h90, 5'h06, 5'h00, 1'b1},
        {8'h92, 5'h06, 5'h08, 1'b0},
        {8'h38, 5'h04, 5'h02, 1'b0},
        {8'h91, 5'h00, 5'h00, 1'b1}
    };
    ricg_gate ricg_gate_inst (
        .clk(clk), .nrst(nrst), .ce(ce), .remote_in(remote_in), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .ready(ready), .error(error), .emergency_stop_active(emergency_stop_active),
        .emergency_stop_clear(emergency_stop_clear), .guard_open_flag(guard_open_flag), .running(running),
        .paused(paused), .manual_teaching_flag(manual_teaching_flag), .drive_power_on_all(32'h0000_0020),
        .arm_at_park_all(32'h0000_0010), .full_power_all(32'h0000_0000), .calibration_needed_all(32'h0000_0000),
        .high_power_request(high_power_request), .automatic_mode_flag(automatic_mode_flag),
        .start_pulse(start_pulse), .program_select(program_select), .stop_pulse(stop_pulse),
        .pause_pulse(pause_pulse), .continue_pulse(continue_pulse), .reset_pulse(reset_pulse),
        .low_power_hold(low_power_hold), .high_power_grant(high_power_grant), .high_power_refuse(high_power_refuse),
        .robot_number_line(robot_number_line), .robot_status_select(robot_status_select),
        .drive_power_on(drive_power_on), .arm_at_park(arm_at_park), .full_power_flag(), .calibration_needed(),
        .command_reject_flag(command_reject_flag), .irq(irq)
    );
    ricg_host_model ricg_host_model_inst (.clk(clk), .nrst(nrst), .req(req), .obey(obey),
        .auto_on(automatic_mode_flag), .ready(ready), .idx(hidx), .levels(levels), .remote_in(remote_in), .busy(busy));
    always #50 clk = ~clk;
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        `CHK(rdata, e)
    endtask
    // One command edge from the host; collects {reset,continue,pause,stop,start}
    task automatic fire(input logic [4:0] b, input logic [4:0] ep, input logic er);
        logic [4:0] seen;
        int k;
        seen = 5'h00;
        k = 0;
        req <= 1'b1;
        hidx <= b;
        @(posedge clk);
        req <= 1'b0;
        do begin
            @(posedge clk);
            seen |= {reset_pulse, continue_pulse, pause_pulse, stop_pulse, start_pulse};
            k++;
        end while (busy && k < 40);
        `CHK(seen, ep)
        `CHK(command_reject_flag, er)
        if (busy) begin
            bad_count++;
            $display("Error %0t: host model hung", $time);
            stop_test();
        end
    endtask
    initial begin
        {clk, nrst, wr, rd, req, obey, high_power_request} = 7'h00;
        {ready, error, emergency_stop_active, emergency_stop_clear, guard_open_flag, running, paused} = 7'h48;
        {ce, manual_teaching_flag, addr, wdata, hidx, levels} = {1'b1, 1'b0, 8'h00, 32'h0, 5'h00, 32'h0};
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rchk(ADDR_CTRL, 32'h0000_0004);
        rchk(ADDR_MAP_BASE + 8'h1C, 32'h0000_0024);
        rchk(ADDR_IRQ_EN, 32'h0000_0000);
        rchk(8'h3C, 32'h0000_0000);
        `CHK(automatic_mode_flag, 1'b0)
        fire(5'h00, 5'h00, 1'b0);
        $display("test reset and remote off done");
        wreg(ADDR_CTRL, 32'h0000_0005);
        @(posedge clk);
        `CHK(automatic_mode_flag, 1'b1)
        guard_open_flag <= 1'b1;
        fire(5'h00, 5'h00, 1'b0);
        rchk(ADDR_STAT, 32'h0000_000B);
        guard_open_flag <= 1'b0;
        wreg(ADDR_CTRL, 32'h0000_0007);
        wreg(ADDR_IRQ_EN, 32'h0000_0007);
        wreg(ADDR_IRQ_CLR, 32'h0000_0007);
        levels <= 32'h0000_000A;
        obey <= 1'b1;
        fire(5'h00, 5'h01, 1'b0);
        `CHK(program_select, 6'h05)
        rchk(ADDR_IRQ_STAT, 32'h0000_0001);
        `CHK(irq, 1'b1)
        wreg(ADDR_IRQ_EN, 32'h0000_0006);
        `CHK(irq, 1'b0)
        wreg(ADDR_IRQ_EN, 32'h0000_0007);
        wreg(ADDR_IRQ_CLR, 32'h0000_0001);
        `CHK(irq, 1'b0)
        $display("test start and interrupt done");
        obey <= 1'b0;
        for (n = 0; n < 13; n++) begin
            {ready, error, emergency_stop_active, emergency_stop_clear, guard_open_flag, running, paused,
                manual_teaching_flag} <= ROWS[n][18:11];
            @(posedge clk);
            fire(ROWS[n][10:6], ROWS[n][5:1], ROWS[n][0]);
        end
        `CHK(automatic_mode_flag, 1'b0)
        $display("test acceptance table done");
        wreg(ADDR_MAP_BASE + 8'h2C, 32'h0000_002E);
        levels[14] <= 1'b1;
        sp = 1'b0;
        for (n = 0; n < 10 && low_power_hold !== 1'b1; n++) begin
            @(posedge clk);
            sp |= stop_pulse;
        end
        `CHK(low_power_hold, 1'b1)
        `CHK(sp, 1'b1)
        if (low_power_hold !== 1'b1) begin
            stop_test();
        end
        high_power_request <= 1'b1;
        @(posedge clk);
        high_power_request <= 1'b0;
        @(posedge clk);
        `CHK(high_power_refuse, 1'b1)
        `CHK(high_power_grant, 1'b0)
        levels[14] <= 1'b0;
        rchk(ADDR_IRQ_STAT, 32'h0000_0007);
        @(posedge clk);
        high_power_request <= 1'b1;
        @(posedge clk);
        high_power_request <= 1'b0;
        @(posedge clk);
        `CHK(high_power_grant, 1'b1)
        `CHK(low_power_hold, 1'b0)
        // Forced entry again, now set to pause instead of stop
        wreg(ADDR_CTRL, 32'h0000_0003);
        levels[14] <= 1'b1;
        sp = 1'b0;
        for (n = 0; n < 10 && low_power_hold !== 1'b1; n++) begin
            @(posedge clk);
            sp |= pause_pulse & ~stop_pulse;
        end
        `CHK(low_power_hold, 1'b1)
        `CHK(sp, 1'b1)
        if (low_power_hold !== 1'b1) begin
            stop_test();
        end
        levels[14] <= 1'b0;
        $display("test forced power done");
        {ready, error, emergency_stop_active, emergency_stop_clear, guard_open_flag, running, paused,
            manual_teaching_flag} <= 8'h90;
        wreg(ADDR_MAP_BASE + 8'h30, 32'h0000_0028);
        for (n = 0; n < 5; n++) begin
            wreg(8'(ADDR_MAP_BASE + 8'h34 + 8'(4 * n)), 32'(6'h29 + 6'(n)));
        end
        levels[13:9] <= 5'h05;
        fire(5'h08, 5'h00, 1'b0);
        `CHK(robot_number_line, 5'h05)
        `CHK(robot_status_select, 5'h05)
        `CHK(drive_power_on, 1'b1)
        `CHK(arm_at_park, 1'b0)
        $display("test robot select done");
        stop_test();
    end
endmodule
bind ricg_gate ricg_gate_sva #(.IN_W(IN_W)) ricg_gate_sva_inst (
    .clk(clk), .nrst(nrst), .remote_in(remote_in), .ready(ready), .error(error),
    .emergency_stop_active(emergency_stop_active), .emergency_stop_clear(emergency_stop_clear),
    .guard_open_flag(guard_open_flag), .running(running), .paused(paused),
    .manual_teaching_flag(manual_teaching_flag), .high_power_request(high_power_request),
    .automatic_mode_flag(automatic_mode_flag), .start_pulse(start_pulse), .program_select(program_select),
    .pause_pulse(pause_pulse), .continue_pulse(continue_pulse), .reset_pulse(reset_pulse),
    .low_power_hold(low_power_hold), .high_power_refuse(high_power_refuse),
    .command_reject_flag(command_reject_flag)
);
`default_nettype wire
